// ==== inc/ick_params.svh ====
// constants for the input counter and key lockout block
// assumes a single 125 MHz clock domain; included by bare name
`ifndef ICK_PARAMS_SVH
`define ICK_PARAMS_SVH

`define ICK_CNT_W 16
`define ICK_CNT_ZERO 16'h0000
`define ICK_CNT_ONE 16'h0001

`define ICK_NPINS 18
`define ICK_NKEYS 10
`define ICK_PINS_ZERO 18'h00000
`define ICK_KEYS_ZERO 10'h000

`define ICK_PIN_ALL_CLR 0
`define ICK_PIN_UP_CLR 1
`define ICK_PIN_DN_CLR 2
`define ICK_PIN_UP_ADD 3
`define ICK_PIN_UP_SUB 4
`define ICK_PIN_DN_ADD 5
`define ICK_PIN_DN_SUB 6
`define ICK_PIN_START_INH 7
`define ICK_PIN_LOCK_LO 8
`define ICK_PIN_LOCK_HI 17

`define ICK_KEY_MENU 0
`define ICK_KEY_READ 1
`define ICK_KEY_WRITE 2
`define ICK_KEY_TEACH_ENTRY 3
`define ICK_KEY_TEACH_MODIFY 4
`define ICK_KEY_TEACH_CONVERT 5
`define ICK_KEY_PROGRAM 6
`define ICK_KEY_IO_SETTING 7
`define ICK_KEY_FUNCTION 8
`define ICK_KEY_SPEED 9

`endif

// ==== inc/ick_pkg.sv ====
// types shared by the input counter and key lockout modules
// assumes ick_params.svh on the include path
`include "ick_params.svh"

package ick_pkg;
    typedef logic [`ICK_CNT_W-1:0] ick_cnt_t;
    typedef logic [`ICK_NPINS-1:0] ick_pins_t;
    typedef logic [`ICK_NKEYS-1:0] ick_keys_t;
endpackage

// ==== inc/ick_pin_if.sv ====
// pin bundle between the lockout core and its input filter
// assumes both ends share mclk_i
`include "ick_params.svh"

interface ick_pin_if;
    logic [`ICK_NPINS-1:0] raw;
    logic [`ICK_NPINS-1:0] level;
    logic [`ICK_NPINS-1:0] rise;
    modport filt (input raw, output level, output rise);
    modport core (output raw, input level, input rise);
endinterface

// ==== rtl/ick_sync.sv ====
// three-stage synchroniser and agreement filter for the external pins
// assumes asynchronous pins; ce_i freezes every stage
`include "ick_params.svh"

module ick_sync
    import ick_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    ick_pin_if.filt pins
);
    ick_pins_t meta;
    ick_pins_t sync2;
    ick_pins_t sync3;
    ick_pins_t level;
    ick_pins_t rise;
    ick_pins_t next_meta;
    ick_pins_t next_sync2;
    ick_pins_t next_sync3;
    ick_pins_t next_level;
    ick_pins_t next_rise;

    always_comb begin
        next_meta = meta;
        next_sync2 = sync2;
        next_sync3 = sync3;
        next_level = level;
        next_rise = rise;
        if (ce_i) begin
            next_meta = pins.raw;
            next_sync2 = meta;
            next_sync3 = sync2;
            // level moves only once stages two and three agree
            next_level = (sync2 & sync3) | (level & (sync2 | sync3));
            next_rise = next_level & ~level;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            meta <= `ICK_PINS_ZERO;
            sync2 <= `ICK_PINS_ZERO;
            sync3 <= `ICK_PINS_ZERO;
            level <= `ICK_PINS_ZERO;
            rise <= `ICK_PINS_ZERO;
        end else begin
            meta <= next_meta;
            sync2 <= next_sync2;
            sync3 <= next_sync3;
            level <= next_level;
            rise <= next_rise;
        end
    end

    assign pins.level = level;
    assign pins.rise = rise;
endmodule // ick_sync

// ==== rtl/ick_top.sv ====
// production counters, start inhibit and operator key lockout
// assumes external switch pins are asynchronous; panel keys and start
// request come from logic on mclk_i
`include "ick_params.svh"

module ick_top
    import ick_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic all_counter_clear_i,
    input wire logic up_counter_clear_i,
    input wire logic down_counter_clear_i,
    input wire logic up_count_add_i,
    input wire logic up_count_sub_i,
    input wire logic down_count_add_i,
    input wire logic down_count_sub_i,
    input wire logic start_inhibit_i,
    input wire logic menu_key_lock_i,
    input wire logic pattern_read_lock_i,
    input wire logic pattern_write_lock_i,
    input wire logic teach_entry_lock_i,
    input wire logic teach_modify_lock_i,
    input wire logic teach_convert_lock_i,
    input wire logic program_key_lock_i,
    input wire logic io_setting_key_lock_i,
    input wire logic function_key_lock_i,
    input wire logic speed_key_lock_i,
    input wire logic start_req_i,
    input wire logic [`ICK_NKEYS-1:0] key_press_i,
    output logic start_go_o,
    output logic [`ICK_NKEYS-1:0] key_accept_o,
    output logic [`ICK_NKEYS-1:0] key_locked_o,
    output logic start_inhibited_o,
    output logic [`ICK_CNT_W-1:0] up_count_o,
    output logic [`ICK_CNT_W-1:0] down_count_o
);
    ick_pin_if pins ();

    ick_cnt_t up_cnt;
    ick_cnt_t down_cnt;
    ick_cnt_t next_up_cnt;
    ick_cnt_t next_down_cnt;
    ick_keys_t key_accept;
    ick_keys_t next_key_accept;
    ick_keys_t key_locked;
    ick_keys_t next_key_locked;
    ick_keys_t lock_level;
    logic start_go;
    logic next_start_go;
    logic inhibited;
    logic next_inhibited;

    logic all_clr;
    logic up_clr;
    logic dn_clr;
    logic up_add;
    logic up_sub;
    logic dn_add;
    logic dn_sub;
    logic inhibit_level;

    assign pins.raw[`ICK_PIN_ALL_CLR] = all_counter_clear_i;
    assign pins.raw[`ICK_PIN_UP_CLR] = up_counter_clear_i;
    assign pins.raw[`ICK_PIN_DN_CLR] = down_counter_clear_i;
    assign pins.raw[`ICK_PIN_UP_ADD] = up_count_add_i;
    assign pins.raw[`ICK_PIN_UP_SUB] = up_count_sub_i;
    assign pins.raw[`ICK_PIN_DN_ADD] = down_count_add_i;
    assign pins.raw[`ICK_PIN_DN_SUB] = down_count_sub_i;
    assign pins.raw[`ICK_PIN_START_INH] = start_inhibit_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_MENU] = menu_key_lock_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_READ] = pattern_read_lock_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_WRITE] = pattern_write_lock_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_TEACH_ENTRY] = teach_entry_lock_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_TEACH_MODIFY] = teach_modify_lock_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_TEACH_CONVERT] = teach_convert_lock_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_PROGRAM] = program_key_lock_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_IO_SETTING] = io_setting_key_lock_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_FUNCTION] = function_key_lock_i;
    assign pins.raw[`ICK_PIN_LOCK_LO + `ICK_KEY_SPEED] = speed_key_lock_i;

    ick_sync u_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .pins(pins)
    );

    // clears act on the filtered level, steps on the one-cycle rise
    assign all_clr = pins.level[`ICK_PIN_ALL_CLR];
    assign up_clr = pins.level[`ICK_PIN_UP_CLR];
    assign dn_clr = pins.level[`ICK_PIN_DN_CLR];
    assign up_add = pins.rise[`ICK_PIN_UP_ADD];
    assign up_sub = pins.rise[`ICK_PIN_UP_SUB];
    assign dn_add = pins.rise[`ICK_PIN_DN_ADD];
    assign dn_sub = pins.rise[`ICK_PIN_DN_SUB];
    assign inhibit_level = pins.level[`ICK_PIN_START_INH];
    assign lock_level = pins.level[`ICK_PIN_LOCK_HI:`ICK_PIN_LOCK_LO];

    // add and subtract on the same edge cancel; counters wrap modulo width
    function automatic ick_cnt_t cnt_step(input ick_cnt_t cnt, input logic clr,
                                          input logic inc, input logic dec);
        ick_cnt_t res;
        res = cnt;
        if (clr) begin
            res = `ICK_CNT_ZERO;
        end else if (inc && !dec) begin
            res = cnt + `ICK_CNT_ONE;
        end else if (dec && !inc) begin
            res = cnt - `ICK_CNT_ONE;
        end
        return res;
    endfunction

    always_comb begin
        next_up_cnt = up_cnt;
        next_down_cnt = down_cnt;
        next_key_accept = key_accept;
        next_key_locked = key_locked;
        next_start_go = start_go;
        next_inhibited = inhibited;
        if (ce_i) begin
            next_up_cnt = cnt_step(up_cnt, all_clr || up_clr, up_add, up_sub);
            next_down_cnt = cnt_step(down_cnt, all_clr || dn_clr, dn_add, dn_sub);
            next_start_go = start_req_i && !inhibit_level;
            next_inhibited = inhibit_level;
            next_key_accept = key_press_i & ~lock_level;
            next_key_locked = lock_level;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            up_cnt <= `ICK_CNT_ZERO;
            down_cnt <= `ICK_CNT_ZERO;
            key_accept <= `ICK_KEYS_ZERO;
            key_locked <= `ICK_KEYS_ZERO;
            start_go <= 1'b0;
            inhibited <= 1'b0;
        end else begin
            up_cnt <= next_up_cnt;
            down_cnt <= next_down_cnt;
            key_accept <= next_key_accept;
            key_locked <= next_key_locked;
            start_go <= next_start_go;
            inhibited <= next_inhibited;
        end
    end

    assign up_count_o = up_cnt;
    assign down_count_o = down_cnt;
    assign key_accept_o = key_accept;
    assign key_locked_o = key_locked;
    assign start_go_o = start_go;
    assign start_inhibited_o = inhibited;

    property p_all_clear;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && all_clr) |=> (up_cnt == `ICK_CNT_ZERO) && (down_cnt == `ICK_CNT_ZERO);
    endproperty
    a_all_clear: assert property (p_all_clear) else $error("all clear did not zero both counters");

    property p_up_clear;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && up_clr && !all_clr && !dn_clr && !dn_add && !dn_sub)
            |=> (up_cnt == `ICK_CNT_ZERO) && (down_cnt == $past(down_cnt));
    endproperty
    a_up_clear: assert property (p_up_clear) else $error("up clear wrong or disturbed down counter");

    property p_down_clear;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && dn_clr && !all_clr && !up_clr && !up_add && !up_sub)
            |=> (down_cnt == `ICK_CNT_ZERO) && (up_cnt == $past(up_cnt));
    endproperty
    a_down_clear: assert property (p_down_clear) else $error("down clear wrong or disturbed up counter");

    property p_up_add;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && up_add && !up_sub && !all_clr && !up_clr)
            |=> up_cnt == ick_cnt_t'($past(up_cnt) + `ICK_CNT_ONE);
    endproperty
    a_up_add: assert property (p_up_add) else $error("up counter did not increment");

    property p_up_sub;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && up_sub && !up_add && !all_clr && !up_clr)
            |=> up_cnt == ick_cnt_t'($past(up_cnt) - `ICK_CNT_ONE);
    endproperty
    a_up_sub: assert property (p_up_sub) else $error("up counter did not decrement");

    property p_down_add;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && dn_add && !dn_sub && !all_clr && !dn_clr)
            |=> down_cnt == ick_cnt_t'($past(down_cnt) + `ICK_CNT_ONE);
    endproperty
    a_down_add: assert property (p_down_add) else $error("down counter did not increment");

    property p_down_sub;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && dn_sub && !dn_add && !all_clr && !dn_clr)
            |=> down_cnt == ick_cnt_t'($past(down_cnt) - `ICK_CNT_ONE);
    endproperty
    a_down_sub: assert property (p_down_sub) else $error("down counter did not decrement");

    // a held add pin must not keep counting after its first step
    property p_single_step;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && pins.level[`ICK_PIN_UP_ADD] && !up_add && !up_sub && !all_clr && !up_clr)
            |=> $stable(up_cnt);
    endproperty
    a_single_step: assert property (p_single_step) else $error("up counter moved without an edge");

    property p_clear_wins;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && (all_clr || dn_clr) && (dn_add || dn_sub)) |=> down_cnt == `ICK_CNT_ZERO;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("count step beat a clear");

    property p_start_block;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && inhibit_level) |=> !start_go_o && start_inhibited_o;
    endproperty
    a_start_block: assert property (p_start_block) else $error("start issued while inhibited");

    property p_start_pass;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && !inhibit_level && start_req_i) |=> start_go_o && !start_inhibited_o;
    endproperty
    a_start_pass: assert property (p_start_pass) else $error("start refused with no inhibit");

    property p_key_lock;
        @(posedge mclk_i) disable iff (reset_i)
        ce_i |=> ((key_accept_o & $past(lock_level)) == `ICK_KEYS_ZERO)
            && (key_locked_o == $past(lock_level))
            && (key_accept_o == ($past(key_press_i) & ~$past(lock_level)));
    endproperty
    a_key_lock: assert property (p_key_lock) else $error("locked key press was accepted");

    property p_up_clear_wins;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && (all_clr || up_clr) && (up_add || up_sub)) |=> up_cnt == `ICK_CNT_ZERO;
    endproperty
    a_up_clear_wins: assert property (p_up_clear_wins) else $error("count step beat an up clear");

    // held pins on the other three step inputs must not keep counting either
    property p_down_held;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && pins.level[`ICK_PIN_DN_ADD] && !dn_add && !dn_sub && !all_clr && !dn_clr)
            |=> $stable(down_cnt);
    endproperty
    a_down_held: assert property (p_down_held) else $error("held add moved down counter");

    property p_up_sub_held;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && pins.level[`ICK_PIN_UP_SUB] && !up_add && !up_sub && !all_clr && !up_clr)
            |=> $stable(up_cnt);
    endproperty
    a_up_sub_held: assert property (p_up_sub_held) else $error("held subtract moved up counter");

    property p_down_sub_held;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && pins.level[`ICK_PIN_DN_SUB] && !dn_add && !dn_sub && !all_clr && !dn_clr)
            |=> $stable(down_cnt);
    endproperty
    a_down_sub_held: assert property (p_down_sub_held) else $error("held subtract moved down counter");

    // a low clock enable must hold every output
    property p_freeze;
        @(posedge mclk_i) disable iff (reset_i)
        !ce_i |=> $stable(up_cnt) && $stable(down_cnt) && $stable(key_accept_o)
            && $stable(key_locked_o) && $stable(start_go_o) && $stable(start_inhibited_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

    // add and subtract on one edge cancel out
    property p_step_cancel;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && up_add && up_sub && !all_clr && !up_clr) |=> $stable(up_cnt);
    endproperty
    a_step_cancel: assert property (p_step_cancel) else $error("add and subtract did not cancel");

    property p_inhibit_flag;
        @(posedge mclk_i) disable iff (reset_i)
        ce_i |=> start_inhibited_o == $past(inhibit_level);
    endproperty
    a_inhibit_flag: assert property (p_inhibit_flag) else $error("inhibit flag does not follow its pin");

    // a start goes out only for a request in the cycle before
    property p_start_follows;
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && !start_req_i) |=> !start_go_o;
    endproperty
    a_start_follows: assert property (p_start_follows) else $error("start issued with no request");

endmodule // ick_top

// ==== verification/ick_switch_model.sv ====
// external switch model driving the counter, inhibit and lockout pins
// assumes pins are sampled on mclk_i; a released switch reads low
`include "ick_params.svh"

module ick_switch_model (
    input wire logic mclk_i,
    output logic [`ICK_NPINS-1:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pins_o = `ICK_PINS_ZERO;

    // held and released at least 4 cycles so the filter keeps every step
    task automatic pulse(input int idx, input int hold);
        @(posedge mclk_i) #1 pins_o[idx] = 1'b1;
        repeat (hold) @(posedge mclk_i);
        #1 pins_o[idx] = 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask

    // two pins raised together, as for an add and a subtract on one edge
    task automatic pulse_pair(input int a, input int b, input int hold);
        @(posedge mclk_i) #1 pins_o[a] = 1'b1;
        pins_o[b] = 1'b1;
        repeat (hold) @(posedge mclk_i);
        #1 pins_o[a] = 1'b0;
        pins_o[b] = 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask

    task automatic set_pin(input int idx, input logic v);
        @(posedge mclk_i) #1 pins_o[idx] = v;
    endtask

    task automatic set_locks(input logic [`ICK_NKEYS-1:0] m);
        @(posedge mclk_i) #1 pins_o[`ICK_PIN_LOCK_HI:`ICK_PIN_LOCK_LO] = m;
    endtask
endmodule // ick_switch_model

// ==== verification/tb_input_counter_key_lockout.sv ====
// self-checking bench for ick_top: counters, start inhibit, key lockout
// assumes ick_switch_model drives the pins; keys and start come from here
`include "ick_params.svh"

module tb_input_counter_key_lockout
    import ick_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    logic start_req_i = 1'b0;
    ick_keys_t key_press_i = `ICK_KEYS_ZERO;
    ick_pins_t pins;
    logic start_go_o, start_inhibited_o;
    ick_keys_t key_accept_o, key_locked_o, mask, kp;
    ick_cnt_t up_count_o, down_count_o;
    ick_cnt_t up_m = `ICK_CNT_ZERO;
    ick_cnt_t dn_m = `ICK_CNT_ZERO;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    always #4 mclk_i = ~mclk_i;

    ick_switch_model sw (.mclk_i(mclk_i), .pins_o(pins));

    ick_top dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
        .all_counter_clear_i(pins[`ICK_PIN_ALL_CLR]), .up_counter_clear_i(pins[`ICK_PIN_UP_CLR]),
        .down_counter_clear_i(pins[`ICK_PIN_DN_CLR]), .up_count_add_i(pins[`ICK_PIN_UP_ADD]),
        .up_count_sub_i(pins[`ICK_PIN_UP_SUB]), .down_count_add_i(pins[`ICK_PIN_DN_ADD]),
        .down_count_sub_i(pins[`ICK_PIN_DN_SUB]), .start_inhibit_i(pins[`ICK_PIN_START_INH]),
        .menu_key_lock_i(pins[8]), .pattern_read_lock_i(pins[9]), .pattern_write_lock_i(pins[10]),
        .teach_entry_lock_i(pins[11]), .teach_modify_lock_i(pins[12]), .teach_convert_lock_i(pins[13]),
        .program_key_lock_i(pins[14]), .io_setting_key_lock_i(pins[15]),
        .function_key_lock_i(pins[16]), .speed_key_lock_i(pins[17]),
        .start_req_i(start_req_i), .key_press_i(key_press_i), .start_go_o(start_go_o),
        .key_accept_o(key_accept_o), .key_locked_o(key_locked_o),
        .start_inhibited_o(start_inhibited_o), .up_count_o(up_count_o), .down_count_o(down_count_o)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // counters wrap both ways, so no saturation in the model
    task automatic upd(input int op);
        case (op)
            `ICK_PIN_ALL_CLR: begin
                up_m = `ICK_CNT_ZERO;
                dn_m = `ICK_CNT_ZERO;
            end
            `ICK_PIN_UP_CLR: up_m = `ICK_CNT_ZERO;
            `ICK_PIN_DN_CLR: dn_m = `ICK_CNT_ZERO;
            `ICK_PIN_UP_ADD: up_m = up_m + `ICK_CNT_ONE;
            `ICK_PIN_UP_SUB: up_m = up_m - `ICK_CNT_ONE;
            `ICK_PIN_DN_ADD: dn_m = dn_m + `ICK_CNT_ONE;
            `ICK_PIN_DN_SUB: dn_m = dn_m - `ICK_CNT_ONE;
            default: ;
        endcase
    endtask

    task automatic cmp();
        check("up_count", up_count_o, up_m);
        check("down_count", down_count_o, dn_m);
    endtask

    task automatic step(input int op, input int hold);
        sw.pulse(op, hold);
        upd(op);
        cmp();
    endtask

    // clear held while a step arrives; the step survives only on a counter the clear does not cover
    task automatic race(input int clr, input int op);
        sw.set_pin(clr, 1'b1);
        repeat (8) @(posedge mclk_i);
        sw.pulse(op, 4);
        upd(op);
        upd(clr);
        cmp();
        sw.set_pin(clr, 1'b0);
        repeat (8) @(posedge mclk_i);
        cmp();
    endtask

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        void'($urandom(20));
        repeat (3) @(posedge mclk_i);
        #1 reset_i = 1'b0;
        cmp();
        step(`ICK_PIN_UP_SUB, 4);
        step(`ICK_PIN_DN_ADD, 4);
        step(`ICK_PIN_DN_SUB, 4);
        step(`ICK_PIN_DN_SUB, 4);
        repeat (30) step($urandom_range(6, 0), 4);
        step(`ICK_PIN_UP_ADD, 40);
        race(`ICK_PIN_UP_CLR, `ICK_PIN_UP_ADD);
        race(`ICK_PIN_ALL_CLR, `ICK_PIN_DN_SUB);
        step(`ICK_PIN_UP_ADD, 4);
        race(`ICK_PIN_DN_CLR, `ICK_PIN_UP_SUB);
        // a step made while frozen must never be seen
        @(posedge mclk_i) #1 ce_i = 1'b0;
        sw.pulse(`ICK_PIN_UP_ADD, 4);
        @(posedge mclk_i) #1 ce_i = 1'b1;
        repeat (8) @(posedge mclk_i);
        cmp();
        // add and subtract rising together must leave the count alone
        sw.pulse_pair(`ICK_PIN_UP_ADD, `ICK_PIN_UP_SUB, 4);
        cmp();
        for (int i = 0; i < 16; i++) begin
            mask = (i < 10) ? (10'h001 << i) : 10'($urandom);
            kp = (i < 10) ? 10'h3FF : 10'($urandom);
            sw.set_locks(mask);
            repeat (8) @(posedge mclk_i);
            check("key_locked", key_locked_o, mask);
            @(posedge mclk_i) #1 key_press_i = kp;
            @(posedge mclk_i) #1 key_press_i = `ICK_KEYS_ZERO;
            check("key_accept", key_accept_o, kp & ~mask);
        end
        for (int inh = 1; inh >= 0; inh--) begin
            sw.set_pin(`ICK_PIN_START_INH, inh[0]);
            repeat (8) @(posedge mclk_i);
            check("start_inhibited", start_inhibited_o, inh[0]);
            @(posedge mclk_i) #1 start_req_i = 1'b1;
            @(posedge mclk_i) #1 start_req_i = 1'b0;
            check("start_go", start_go_o, !inh[0]);
        end
        // a reset in mid-run drops both counts and every flag
        step(`ICK_PIN_DN_ADD, 4);
        @(posedge mclk_i) #1 reset_i = 1'b1;
        @(posedge mclk_i) #1 reset_i = 1'b0;
        up_m = `ICK_CNT_ZERO;
        dn_m = `ICK_CNT_ZERO;
        cmp();
        check("key_locked", key_locked_o, `ICK_KEYS_ZERO);
        final_report();
    end
endmodule // tb_input_counter_key_lockout
